// >>> hw/arc_pkg.sv
// Shared constants for the converter reference calibration block.
// Assumes a single 50 MHz system clock and byte-addressed register access.
`default_nettype none
package arc_pkg;
  // Clock and update timing
  localparam int CLK_MHZ = 50;
  localparam int UPDATE_PERIOD_US = 1000;
  localparam int UPDATE_CYCLES = UPDATE_PERIOD_US * CLK_MHZ;
  // Widths
  localparam int ACC_W = 24;
  localparam int DAC_W = 5;
  localparam int ADC_W = 3;
  localparam int RSSI_W = 6;
  localparam int REG_W = 8;
  localparam int ADDR_W = 8;
  localparam int BUS_W = 32;
  localparam int BE_W = 4;
  localparam int TADDR_W = 5;
  // Register byte offsets; the two low address bits are ignored
  localparam logic [7:0] OFS_MODE = 8'h08;
  localparam logic [7:0] OFS_INC = 8'h0c;
  localparam logic [7:0] OFS_DEC = 8'h10;
  localparam logic [7:0] OFS_TADDR = 8'h70;
  localparam logic [7:0] OFS_TMON = 8'h74;
  // Fields and reset values
  localparam int MODE_LSB = 3;
  localparam logic [7:0] RST_MODE = 8'h00;
  localparam logic [7:0] RST_INC = 8'h02;
  localparam logic [7:0] RST_DEC = 8'hff;
  localparam logic [4:0] RST_TADDR = 5'h00;
  // Converter full-scale codes, both polarities
  localparam logic [2:0] ADC_FS_LO = 3'h0;
  localparam logic [2:0] ADC_FS_HI = 3'h7;
  // Test bus modes
  localparam logic [4:0] TM_RSSI = 5'h03;
  localparam logic [4:0] TM_ADCAL = 5'h0c;
  localparam logic [4:0] TM_IQ = 5'h15;
  localparam logic [4:0] TM_ACC_LO = 5'h19;
  localparam logic [4:0] TM_ACC_HI = 5'h1a;
  localparam int ACC_HI_LSB = 9;
  // Calibration modes
  typedef enum logic [1:0] {
    ARC_OFF_A = 2'b00,
    ARC_OFF_B = 2'b01,
    ARC_TRACK = 2'b10,
    ARC_RXEN = 2'b11
  } arc_mode_t;
endpackage : arc_pkg
`default_nettype wire

// >>> hw/arc_avmm_port.sv
// Avalon-MM slave handshake for the calibration registers.
// Assumes the master holds a request until it sees waitrequest low.
`timescale 1ns/10ps
`default_nettype none
module arc_avmm_port (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Avalon-MM slave
  input wire logic read,
  input wire logic write,
  output logic waitrequest,
  output logic [arc_pkg::BUS_W-1:0] readdata,
  // Register file side
  input wire logic [arc_pkg::REG_W-1:0] rd_value,
  output logic wr_stb
);
  import arc_pkg::*;

  typedef struct packed {
    logic ack;
    logic [REG_W-1:0] rdata;
  } arc_port_t;

  arc_port_t st_r;
  arc_port_t st_nxt;

  // One wait cycle per request; read data is captured in that wait cycle
  always_comb begin
    st_nxt = st_r;
    st_nxt.ack = (read | write) & ~st_r.ack;
    if ((read | write) & ~st_r.ack) begin
      st_nxt.rdata = read ? rd_value : '0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Handshake outputs
  assign waitrequest = (read | write) & ~st_r.ack;
  assign wr_stb = write & st_r.ack;
  assign readdata = {{(BUS_W - REG_W){1'b0}}, st_r.rdata};

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_bus_answer_once: assert property ((read | write) && waitrequest |=> !(read | write) || !waitrequest)
    else $error("Request not answered after one wait cycle");
endmodule : arc_avmm_port
`default_nettype wire

// >>> hw/arc_cal_accum.sv
// Saturating calibration accumulator with mid-scale preset.
// Assumes step_en is a single-cycle strobe per converter sample.
`timescale 1ns/10ps
`default_nettype none
module arc_cal_accum #(
  parameter int ACC_W = arc_pkg::ACC_W
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Control
  input wire logic preset,
  input wire logic step_en,
  input wire logic full_scale,
  input wire logic [arc_pkg::REG_W-1:0] inc_step,
  input wire logic [arc_pkg::REG_W-1:0] dec_step,
  // Result
  output logic [ACC_W-1:0] acc
);
  import arc_pkg::*;

  localparam logic [ACC_W-1:0] MID = {1'b1, {(ACC_W - 1){1'b0}}};
  localparam logic [ACC_W-1:0] MAX = '1;

  if (ACC_W <= REG_W) begin : g_bad_width
    $error("Accumulator must be wider than the step registers");
  end

  typedef struct packed {
    logic [ACC_W-1:0] acc;
  } arc_acc_t;

  arc_acc_t st_r;
  arc_acc_t st_nxt;
  logic signed [ACC_W+1:0] delta;
  logic signed [ACC_W+1:0] sum;

  always_comb begin
    st_nxt = st_r;
    delta = full_scale ? $signed({{(ACC_W - REG_W + 2){1'b0}}, inc_step})
                       : $signed({{(ACC_W - REG_W + 2){dec_step[REG_W-1]}}, dec_step});
    sum = $signed({2'b00, st_r.acc}) + delta;
    if (preset) begin
      st_nxt.acc = MID;
    end else if (step_en) begin
      if (sum < 0) begin
        st_nxt.acc = '0;
      end else if (sum > $signed({2'b00, MAX})) begin
        st_nxt.acc = MAX;
      end else begin
        st_nxt.acc = sum[ACC_W-1:0];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_r <= '{acc: MID};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign acc = st_r.acc;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_acc_preset_mid: assert property (preset |=> acc == MID)
    else $error("Accumulator not preset to mid scale");
  a_acc_inc_step: assert property (!preset && step_en && full_scale && acc < MAX - 8'hff
                                   |=> acc == $past(acc) + $past(inc_step))
    else $error("Accumulator did not add the positive step");
  a_acc_dec_step: assert property (!preset && step_en && !full_scale && dec_step == 8'hff && acc != '0
                                   |=> acc == $past(acc) - 1'b1)
    else $error("Accumulator did not apply the negative step");
  a_acc_hold_idle: assert property (!preset && !step_en |=> $stable(acc))
    else $error("Accumulator moved without a sample");
endmodule : arc_cal_accum
`default_nettype wire

// >>> hw/arc_adc_ref_cal.sv
// Converter reference calibration loop with its registers and test bus.
// Assumes converter and signal-strength samples arrive as strobes synchronous to clk_sys.
`timescale 1ns/10ps
`default_nettype none
module arc_adc_ref_cal #(
  parameter int UPDATE_CYCLES_P = arc_pkg::UPDATE_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Avalon-MM register slave
  input wire logic [arc_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [arc_pkg::BUS_W-1:0] writedata,
  input wire logic [arc_pkg::BE_W-1:0] byteenable,
  output logic [arc_pkg::BUS_W-1:0] readdata,
  output logic waitrequest,
  // Converter samples
  input wire logic adc_sample_stb,
  input wire logic [arc_pkg::ADC_W-1:0] adc_i,
  input wire logic [arc_pkg::ADC_W-1:0] adc_q,
  // Receiver status
  input wire logic rx_tracking,
  input wire logic receive_enable_input,
  // Signal strength converter
  input wire logic rssi_stb,
  input wire logic [arc_pkg::RSSI_W-1:0] rssi_adc,
  // Outputs
  output logic [arc_pkg::DAC_W-1:0] ref_adjust_dac,
  output logic cal_active,
  output logic [arc_pkg::RSSI_W-1:0] channel_clear_assessment_rssi,
  output logic [arc_pkg::REG_W-1:0] test_bus
);
  import arc_pkg::*;

  localparam int CNT_W = $clog2(UPDATE_CYCLES_P);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(UPDATE_CYCLES_P - 1);
  localparam logic [DAC_W-1:0] DAC_MID = {1'b1, {(DAC_W - 1){1'b0}}};

  // Refuse update periods the counter cannot serve
  if (UPDATE_CYCLES_P < 2) begin : g_bad_period
    $error("Update period must be at least two cycles");
  end

  typedef struct packed {
    logic [REG_W-1:0] cal_mode_config_reg;
    logic [REG_W-1:0] cal_increment_reg;
    logic [REG_W-1:0] cal_decrement_step;
    logic [TADDR_W-1:0] test_addr;
    logic [CNT_W-1:0] tick_cnt;
    logic [DAC_W-1:0] dac;
    logic [RSSI_W-1:0] rssi;
    logic active;
    logic [REG_W-1:0] test;
  } arc_state_t;

  arc_state_t st_r;
  arc_state_t st_nxt;
  arc_mode_t mode;
  logic preset;
  logic run;
  logic full_scale;
  logic step_en;
  logic tick;
  logic wr_stb;
  logic [REG_W-1:0] rd_value;
  logic [ACC_W-1:0] acc;

  // Address match with the two low address bits ignored
  function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
    reg_hit = (a[ADDR_W-1:2] == ofs[ADDR_W-1:2]);
  endfunction : reg_hit

  // Saturation at either end of the converter range
  function automatic logic at_full_scale(input logic [ADC_W-1:0] code);
    at_full_scale = (code == ADC_FS_LO) || (code == ADC_FS_HI);
  endfunction : at_full_scale

  // Bus handshake and read data capture
  arc_avmm_port u_port (
    .clk_sys(clk_sys),
    .rst(rst),
    .read(read),
    .write(write),
    .waitrequest(waitrequest),
    .readdata(readdata),
    .rd_value(rd_value),
    .wr_stb(wr_stb)
  );

  // Mode decode from the configuration register
  always_comb begin
    mode = arc_mode_t'(st_r.cal_mode_config_reg[MODE_LSB+1:MODE_LSB]);
    case (mode)
      ARC_TRACK: run = rx_tracking;
      ARC_RXEN: run = receive_enable_input;
      ARC_OFF_A: run = 1'b0;
      ARC_OFF_B: run = 1'b0;
      default: run = 1'b0;
    endcase
    preset = ~st_r.cal_mode_config_reg[MODE_LSB+1];
  end

  assign full_scale = at_full_scale(adc_i) | at_full_scale(adc_q);
  assign step_en = run & adc_sample_stb;
  assign tick = (st_r.tick_cnt == CNT_LAST);

  // The accumulator is kept apart so its saturation is easy to verify alone
  arc_cal_accum #(
    .ACC_W(ACC_W)
  ) u_accum (
    .clk_sys(clk_sys),
    .rst(rst),
    .preset(preset),
    .step_en(step_en),
    .full_scale(full_scale),
    .inc_step(st_r.cal_increment_reg),
    .dec_step(st_r.cal_decrement_step),
    .acc(acc)
  );

  // Register read mux; unmapped offsets read zero
  always_comb begin
    if (reg_hit(address, OFS_MODE)) begin
      rd_value = st_r.cal_mode_config_reg;
    end else if (reg_hit(address, OFS_INC)) begin
      rd_value = st_r.cal_increment_reg;
    end else if (reg_hit(address, OFS_DEC)) begin
      rd_value = st_r.cal_decrement_step;
    end else if (reg_hit(address, OFS_TADDR)) begin
      rd_value = {{(REG_W - TADDR_W){1'b0}}, st_r.test_addr};
    end else if (reg_hit(address, OFS_TMON)) begin
      rd_value = st_r.test;
    end else begin
      rd_value = '0;
    end
  end

  // Next state of the control and output registers
  always_comb begin
    st_nxt = st_r;
    // Writes on low byte lane only
    if (wr_stb && byteenable[0]) begin
      if (reg_hit(address, OFS_MODE)) begin
        st_nxt.cal_mode_config_reg = writedata[REG_W-1:0];
      end
      if (reg_hit(address, OFS_INC)) begin
        st_nxt.cal_increment_reg = writedata[REG_W-1:0];
      end
      if (reg_hit(address, OFS_DEC)) begin
        st_nxt.cal_decrement_step = writedata[REG_W-1:0];
      end
      if (reg_hit(address, OFS_TADDR)) begin
        st_nxt.test_addr = writedata[TADDR_W-1:0];
      end
    end
    st_nxt.tick_cnt = tick ? '0 : st_r.tick_cnt + 1'b1;
    if (preset) begin
      st_nxt.dac = DAC_MID;
    end else if (tick) begin
      st_nxt.dac = acc[ACC_W-1 -: DAC_W];
    end
    if (rssi_stb) begin
      st_nxt.rssi = rssi_adc;
    end
    st_nxt.active = run;
    // Test bus view; one cycle behind the state it shows
    case (st_r.test_addr)
      TM_RSSI: st_nxt.test = {2'b00, st_r.rssi};
      TM_ADCAL: st_nxt.test = {st_r.active, 1'b0, preset, st_r.dac};
      TM_IQ: st_nxt.test = {2'b00, adc_i, adc_q};
      TM_ACC_LO: st_nxt.test = acc[REG_W-1:0];
      TM_ACC_HI: st_nxt.test = acc[ACC_HI_LSB +: REG_W];
      default: st_nxt.test = '0;
    endcase
  end

  // State register; off mode and suggested steps after reset
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_r <= '{cal_mode_config_reg: RST_MODE, cal_increment_reg: RST_INC,
                cal_decrement_step: RST_DEC, test_addr: RST_TADDR, tick_cnt: '0,
                dac: DAC_MID, rssi: '0, active: 1'b0, test: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // Registered outputs
  assign ref_adjust_dac = st_r.dac;
  assign cal_active = st_r.active;
  assign channel_clear_assessment_rssi = st_r.rssi;
  assign test_bus = st_r.test;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_off_dac_mid: assert property (preset |=> ref_adjust_dac == DAC_MID)
    else $error("Reference not held at mid scale while off");
  a_dac_tick_load: assert property (!preset && tick |=> ref_adjust_dac == $past(acc[ACC_W-1 -: DAC_W]))
    else $error("Reference not loaded from top accumulator bits");
  a_dac_hold_between: assert property (!preset && !tick ##1 !preset |-> $stable(ref_adjust_dac))
    else $error("Reference changed between update ticks");
  a_tick_period: assert property (tick |=> st_r.tick_cnt == '0 ##1 !tick)
    else $error("Update tick counter did not restart");
  a_track_gate: assert property (mode == ARC_TRACK && !rx_tracking |-> !step_en)
    else $error("Calibration stepped while not tracking");
  a_rxen_run: assert property (mode == ARC_RXEN && receive_enable_input && adc_sample_stb
                               |-> step_en ##1 cal_active)
    else $error("Calibration idle with receive enabled");
  a_rssi_capture: assert property (rssi_stb |=> channel_clear_assessment_rssi == $past(rssi_adc))
    else $error("Signal strength not captured");
  // A full-scale pin code must reach the accumulator as a positive step, not only the decode
  a_fs_detect: assert property (step_en && (adc_i == ADC_FS_HI || adc_q == ADC_FS_LO)
                                && !(&acc[ACC_W-1 -: REG_W])
                                |=> acc == $past(acc) + $past(st_r.cal_increment_reg))
    else $error("Full-scale sample missed");
  a_mode_write: assert property (wr_stb && byteenable[0] && reg_hit(address, OFS_MODE)
                                 |=> st_r.cal_mode_config_reg == $past(writedata[REG_W-1:0]))
    else $error("Mode register write lost");
endmodule : arc_adc_ref_cal
`default_nettype wire

// >>> tb/arc_if_model.sv
// IF down converter model: 3-bit I/Q codes with a one-cycle sample strobe.
// Assumes the bench raises go for as many cycles as samples it wants.
`timescale 1ns/10ps
`default_nettype none
module arc_if_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Bench control
  input wire logic go,
  input wire logic full,
  // Converter outputs
  output logic adc_sample_stb,
  output logic [2:0] adc_i,
  output logic [2:0] adc_q
);
  logic ph_r;
  // 3-bit I/Q samples
  // Full scale alternates I high and Q low; idle codes toggle so stale data never matches
  always_ff @(posedge clk_sys) begin
    adc_sample_stb <= go && !rst;
    ph_r <= rst ? 1'b0 : ph_r ^ go;
    if (rst) begin
      adc_i <= 3'h0;
      adc_q <= 3'h5;
    end else if (go && full) begin
      adc_i <= ph_r ? 3'h3 : 3'h7;
      adc_q <= ph_r ? 3'h0 : 3'h4;
    end else if (go) begin
      adc_i <= 3'h3;
      adc_q <= 3'h4;
    end else begin
      adc_i <= ~adc_i;
      adc_q <= ~adc_q;
    end
  end
endmodule : arc_if_model
`default_nettype wire

// >>> tb/arc_adc_ref_cal_test.sv
// Self-checking bench for the converter reference calibration block.
// Assumes the IF model drives samples; expected accumulator kept by a local model.
`timescale 1ns/10ps
`default_nettype none
module arc_adc_ref_cal_test;
  import arc_pkg::*;
  localparam int UPD = 16;
  logic clk_sys, rst, read, write, rx_tracking, receive_enable_input, rssi_stb, go, full, chk_tick;
  logic waitrequest, adc_sample_stb, cal_active;
  logic [7:0] address, test_bus, inc_e, dec_e;
  logic [31:0] writedata, readdata, q;
  logic [3:0] byteenable;
  logic [2:0] adc_i, adc_q;
  logic [5:0] rssi_adc, ccar, v6;
  logic [4:0] dac, dac_q;
  logic [23:0] acc_e;
  logic [7:0] ra [6] = '{8'h08, 8'h0c, 8'h10, 8'h70, 8'h00, 8'h0d};
  logic [7:0] rv [6] = '{RST_MODE, RST_INC, RST_DEC, {3'h0, RST_TADDR}, 8'h00, RST_INC};
  int n_errors, n_tests, cyc;
  int ph = -1;

  arc_adc_ref_cal #(.UPDATE_CYCLES_P(UPD)) dut_u (.clk_sys(clk_sys), .rst(rst), .address(address),
    .read(read), .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .adc_sample_stb(adc_sample_stb), .adc_i(adc_i), .adc_q(adc_q),
    .rx_tracking(rx_tracking), .receive_enable_input(receive_enable_input), .rssi_stb(rssi_stb),
    .rssi_adc(rssi_adc), .ref_adjust_dac(dac), .cal_active(cal_active),
    .channel_clear_assessment_rssi(ccar), .test_bus(test_bus));
  arc_if_model if_u (.clk_sys(clk_sys), .rst(rst), .go(go), .full(full),
    .adc_sample_stb(adc_sample_stb), .adc_i(adc_i), .adc_q(adc_q));

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk8

  // One Avalon transfer; holds everything until waitrequest is seen low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d, input logic be);
    int n;
    n = 0;
    @(posedge clk_sys);
    write <= wr;
    read <= !wr;
    address <= a;
    writedata <= {24'h0, d};
    byteenable <= {4{be}};
    do begin
      @(posedge clk_sys);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    if (n >= 50) begin
      n_errors++;
      $display("Error at %0t: bus hang", $time);
    end
    q = readdata;
    write <= 1'b0;
    read <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 1'b1);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00, 1'b1);
    chk8(q[7:0], exp);
    // Upper lanes carry no register bits and must read zero
    chk8(q[31:24] | q[23:16] | q[15:8], 8'h00);
  endtask : rd

  // Sends n samples; the model steps only when the loop should be running
  task automatic run(input int n, input logic f, input logic act);
    longint v;
    @(posedge clk_sys);
    go <= 1'b1;
    full <= f;
    repeat (n) @(posedge clk_sys);
    go <= 1'b0;
    repeat (3) @(posedge clk_sys);
    if (act) for (int k = 0; k < n; k++) begin
      v = longint'(acc_e) + (f ? longint'(inc_e) : longint'(signed'(dec_e)));
      acc_e = v < 0 ? 24'h0 : (v > 24'hffffff ? 24'hffffff : v[23:0]);
    end
  endtask : run

  task automatic chk_acc();
    wr(OFS_TADDR, {3'h0, TM_ACC_LO});
    rd(OFS_TMON, acc_e[7:0]);
    wr(OFS_TADDR, {3'h0, TM_ACC_HI});
    rd(OFS_TMON, acc_e[16:9]);
  endtask : chk_acc

  // Clock at 50 MHz
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // refresh on tick grid
  // Reference changes must all fall on one phase of the update period
  always @(posedge clk_sys) begin
    cyc <= rst ? 0 : cyc + 1;
    dac_q <= dac;
    if (!rst && chk_tick && dac !== dac_q) begin
      if (ph < 0) ph = cyc % UPD;
      else chk8(8'(cyc % UPD), 8'(ph));
    end
  end

  // Watchdog sized well above the longest sample run
  initial begin
    #(60000 * 20);
    n_errors++;
    $display("Error at %0t: timeout", $time);
    summarize();
  end

  // Main sequence
  initial begin
    {rst, read, write, rx_tracking, receive_enable_input, rssi_stb, go, full, chk_tick} = 9'h100;
    address = 8'h00;
    writedata = 32'h0;
    byteenable = 4'h0;
    rssi_adc = 6'h00;
    n_errors = 0;
    n_tests = 0;
    acc_e = 24'h800000;
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    for (int k = 0; k < 6; k++) rd(ra[k], rv[k]);
    chk8({3'h0, dac}, 8'h10);
    bus(1'b1, OFS_INC, 8'h55, 1'b0);
    rd(OFS_INC, RST_INC);
    wr(OFS_INC, 8'h02);
    wr(OFS_DEC, 8'hff);
    inc_e = 8'h02;
    dec_e = 8'hff;
    wr(OFS_MODE, 8'h00);
    run(20, 1'b1, 1'b0);
    chk_acc();
    wr(OFS_MODE, 8'h08);
    run(40, 1'b1, 1'b0);
    chk_acc();
    chk8({3'h0, dac}, 8'h10);
    wr(OFS_MODE, 8'h10);
    receive_enable_input <= 1'b1;
    run(10, 1'b1, 1'b0);
    chk_acc();
    chk8({7'h0, cal_active}, 8'h00);
    rx_tracking <= 1'b1;
    run(3, 1'b1, 1'b1);
    chk_acc();
    chk8({7'h0, cal_active}, 8'h01);
    run(5, 1'b0, 1'b1);
    chk_acc();
    wr(OFS_MODE, 8'h18);
    rx_tracking <= 1'b0;
    run(4, 1'b1, 1'b1);
    chk_acc();
    receive_enable_input <= 1'b0;
    run(4, 1'b1, 1'b0);
    chk_acc();
    receive_enable_input <= 1'b1;
    wr(OFS_MODE, 8'h00);
    acc_e = 24'h800000;
    wr(OFS_INC, 8'hff);
    inc_e = 8'hff;
    wr(OFS_MODE, 8'h10);
    rx_tracking <= 1'b1;
    chk_tick <= 1'b1;
    // Just past the first top-bit boundary, so the reference has to leave mid scale
    run(2060, 1'b1, 1'b1);
    repeat (UPD + 4) @(posedge clk_sys);
    chk8({3'h0, dac}, {3'h0, acc_e[23:19]});
    // Calibration view while running: active, not off, reference code
    wr(OFS_TADDR, {3'h0, TM_ADCAL});
    rd(OFS_TMON, {3'b100, acc_e[23:19]});
    run(33000, 1'b1, 1'b1);
    chk_acc();
    wr(OFS_DEC, 8'h80);
    dec_e = 8'h80;
    run(10, 1'b0, 1'b1);
    chk_acc();
    repeat (UPD + 4) @(posedge clk_sys);
    chk8({3'h0, dac}, {3'h0, acc_e[23:19]});
    chk_tick <= 1'b0;
    wr(OFS_MODE, 8'h00);
    acc_e = 24'h800000;
    repeat (3) @(posedge clk_sys);
    chk8({3'h0, dac}, 8'h10);
    // Off view: idle, off flag set, mid-scale reference
    wr(OFS_TADDR, {3'h0, TM_ADCAL});
    rd(OFS_TMON, 8'h30);
    chk_acc();
    for (int k = 0; k < 2; k++) begin
      v6 = k ? 6'h3f : 6'h2a;
      @(posedge clk_sys);
      rssi_stb <= 1'b1;
      rssi_adc <= v6;
      @(posedge clk_sys);
      rssi_stb <= 1'b0;
      rssi_adc <= ~v6;
      repeat (2) @(posedge clk_sys);
      chk8({2'h0, ccar}, {2'h0, v6});
      wr(OFS_TADDR, {3'h0, TM_RSSI});
      rd(OFS_TMON, {2'h0, v6});
      chk8(test_bus, {2'h0, v6});
    end
    // Live converter codes on the test bus, shown one cycle late
    wr(OFS_TADDR, {3'h0, TM_IQ});
    @(posedge clk_sys);
    v6 = {adc_i, adc_q};
    @(posedge clk_sys);
    chk8(test_bus, {2'h0, v6});
    summarize();
  end
endmodule : arc_adc_ref_cal_test
`default_nettype wire
